// *** design/pte_pkg.sv ***
// constants and types of the pci target termination and error logging block
package pte_pkg;

  // data path and fifo geometry
  localparam int          DW         = 32;
  localparam int          FIFO_DEPTH = 8;
  localparam int          PTR_W      = 3;
  localparam int          CNT_W      = 4;
  localparam logic [3:0]  FIFO_SLOTS = 4'h8;
  localparam logic [3:0]  LINE_SHORT = 4'h4;
  localparam logic [3:0]  LINE_LONG  = 4'h8;
  localparam logic [1:0]  CLINE_LONG = 2'h2;
  localparam int          INT_W      = 3;

  // register byte offsets (low address byte)
  localparam logic [7:0]  OFS_MISC     = 8'h00;
  localparam logic [7:0]  OFS_ERR_CS   = 8'h04;
  localparam logic [7:0]  OFS_ERR_ADDR = 8'h08;
  localparam logic [7:0]  OFS_ERR_DATA = 8'h0c;
  localparam logic [7:0]  OFS_INTERRUPT_CONTROL_REG  = 8'h10;
  localparam logic [7:0]  OFS_INT_STAT = 8'h14;
  localparam logic [7:0]  OFS_INT_DIR  = 8'h18;

  // field positions
  localparam int          MISC_POSTED_WRITE_ENABLE    = 0;
  localparam int          MISC_CLINE   = 1;
  localparam int          ERR_EN       = 0;
  localparam int          ERR_FLAG     = 1;
  localparam int          ERR_CODE     = 4;
  localparam int          ERR_SIZE     = 8;
  localparam int          INT_ERRLOG   = 0;
  localparam int          INT_ABORT    = 1;
  localparam int          INT_DROP     = 2;
  localparam int          DIR_ROUTE    = 0;

  // local bus termination codes
  typedef enum logic [1:0] {
    LB_OK,
    LB_ERR,
    LB_RETRY
  } pte_lbresp_t;

  // one queued posted write
  typedef struct packed {
    logic [DW-1:0] addr;
    logic [DW-1:0] data;
    logic [3:0]    code;
    logic [1:0]    size;
  } pte_ent_t;

  // number of free entries a first write phase needs
  function automatic logic [3:0] lineWords(input logic [1:0] cline);
    lineWords = (cline == CLINE_LONG) ? LINE_LONG : LINE_SHORT;
  endfunction

endpackage

// *** design/pte_target_term.sv ***
// pci target termination, posted write queue and local bus error logging
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Operation
// R1 - retry: stop asserted, trdy deasserted, no data moves
// R2 - posted write first phase retried if fifo lacks cacheline free entries
// R3 - any access retried while a delayed transaction is outstanding
// R4 - burst read retried until its local bus read terminated
// R5 - write retried while a read is incomplete on its destination bus
// R6 - abort: stop asserted with devsel deasserted
// R7 - reads, delayed writes retried until local bus done, then translated
// R8 - local normal gives completion, local error gives target abort
// R9 - local retry hidden; keep retrying pci until normal or error
// R10 - posted write pci termination independent of local outcome
// R11 - logging on and posted write error: capture code, size, set flag
// R12 - logged error latches failing address and data
// R13 - flag set with logging: fifo and target path frozen until cleared
// R14 - logging off: failing posted write dropped, queue continues
// R15 - error log interrupt only when its enable bit is set
// R16 - error interrupt routed to local or pci side by route bit
// R17 - flag cleared by software write; captured values stay until then
module pte_target_term (
  // clock and reset
  input  wire  logic                  mclk,
  input  wire  logic                  rst,
  // apb slave
  input  wire  logic                  psel,
  input  wire  logic                  penable,
  input  wire  logic                  pwrite,
  input  wire  logic [31:0]           paddr,
  input  wire  logic [31:0]           pwdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic [31:0]                 prdata,
  // pci target attempt, one pulse per address phase
  input  wire  logic                  reqValid,
  input  wire  logic                  reqWrite,
  input  wire  logic                  reqFirst,
  input  wire  logic [pte_pkg::DW-1:0] reqAddr,
  input  wire  logic [pte_pkg::DW-1:0] reqData,
  input  wire  logic [3:0]            reqCode,
  input  wire  logic [1:0]            reqSize,
  input  wire  logic                  otherReadBusy,
  // pci termination, active low, valid one cycle after the attempt
  output logic                        stopN,
  output logic                        trdyN,
  output logic                        devselN,
  output logic [pte_pkg::DW-1:0]      respData,
  // local processor bus master
  output logic                        lbReq,
  output logic                        lbWrite,
  output logic [pte_pkg::DW-1:0]      lbAddr,
  output logic [pte_pkg::DW-1:0]      lbData,
  output logic [3:0]                  lbCode,
  output logic [1:0]                  lbSize,
  input  wire  logic                  lbAck,
  input  wire  pte_pkg::pte_lbresp_t  lbResp,
  input  wire  logic [pte_pkg::DW-1:0] lbRdata,
  // interrupts
  output logic                        irqLocal,
  output logic                        irqPci
);
  import pte_pkg::*;

  typedef enum logic [1:0] {D_IDLE, D_RUN, D_DONE} pte_dly_t;
  typedef enum logic [1:0] {L_IDLE, L_POST, L_DLY} pte_lb_t;
  typedef enum logic [1:0] {T_NONE, T_DONE, T_RETRY, T_ABORT} pte_term_t;

  typedef struct packed {
    logic                  posted_write_enable;
    logic [1:0]            cline;
    logic                  logEn;
    logic                  errFlag;
    logic [3:0]            errCode;
    logic [1:0]            errSize;
    logic [DW-1:0]         errAddr;
    logic [DW-1:0]         errData;
    logic [INT_W-1:0]      intMask;
    logic [INT_W-1:0]      intStat;
    logic                  route;
    pte_dly_t              dState;
    logic                  dWrite;
    logic [DW-1:0]         dAddr;
    logic [DW-1:0]         dData;
    logic [3:0]            dCode;
    logic [1:0]            dSize;
    logic                  dErr;
    logic [DW-1:0]         dRdata;
    pte_lb_t               lbState;
    logic                  lbReq;
    logic                  lbWrite;
    logic [DW-1:0]         lbAddr;
    logic [DW-1:0]         lbData;
    logic [3:0]            lbCode;
    logic [1:0]            lbSize;
    pte_ent_t [FIFO_DEPTH-1:0] fifo;
    logic [PTR_W-1:0]      wp;
    logic [PTR_W-1:0]      rp;
    logic [CNT_W-1:0]      cnt;
    logic                  stopN;
    logic                  trdyN;
    logic                  devselN;
    logic [DW-1:0]         respData;
    logic [31:0]           prdata;
  } pte_st_t;

  pte_st_t          s_r;
  pte_st_t          s_nxt;
  logic             frozen;
  logic [CNT_W-1:0] freeSlots;
  logic [CNT_W-1:0] needSlots;

  // pin pattern {stop, trdy, devsel} for each termination kind
  function automatic logic [2:0] termPins(input pte_term_t t);
    unique case (t)
      T_NONE:  termPins = 3'h7;
      T_DONE:  termPins = 3'h4;
      T_RETRY: termPins = 3'h2;
      T_ABORT: termPins = 3'h3;
    endcase
  endfunction

  // true for any mapped register offset
  function automatic logic regKnown(input logic [7:0] a);
    regKnown = (a == OFS_MISC) || (a == OFS_ERR_CS) ||
               (a == OFS_ERR_ADDR) || (a == OFS_ERR_DATA) ||
               (a == OFS_INTERRUPT_CONTROL_REG) || (a == OFS_INT_STAT) ||
               (a == OFS_INT_DIR);
  endfunction

  assign frozen    = s_r.errFlag & s_r.logEn;          // R13
  assign freeSlots = FIFO_SLOTS - s_r.cnt;
  assign needSlots = lineWords(s_r.cline);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic      push;
    logic      pop;
    logic      match;
    pte_term_t term;
    push  = 1'b0;
    pop   = 1'b0;
    match = 1'b0;
    term  = T_NONE;
    s_nxt = s_r;

    // apb: read data latched in setup so it is stable in access
    if (psel && !penable && !pwrite) begin
      case (paddr[7:0])
        OFS_MISC:     s_nxt.prdata = {29'h0, s_r.cline, s_r.posted_write_enable};
        OFS_ERR_CS:   s_nxt.prdata = {22'h0, s_r.errSize, s_r.errCode,
                                      2'h0, s_r.errFlag, s_r.logEn};
        OFS_ERR_ADDR: s_nxt.prdata = s_r.errAddr;
        OFS_ERR_DATA: s_nxt.prdata = s_r.errData;
        OFS_INTERRUPT_CONTROL_REG:  s_nxt.prdata = {29'h0, s_r.intMask};
        OFS_INT_STAT: s_nxt.prdata = {29'h0, s_r.intStat};
        OFS_INT_DIR:  s_nxt.prdata = {31'h0, s_r.route};
        default:      s_nxt.prdata = 32'h0;
      endcase
    end
    if (psel && penable) begin
      if (pwrite) begin
        case (paddr[7:0])
          OFS_MISC: begin
            s_nxt.posted_write_enable  = pwdata[MISC_POSTED_WRITE_ENABLE];
            s_nxt.cline = pwdata[MISC_CLINE +: 2];
          end
          OFS_ERR_CS: begin
            s_nxt.logEn = pwdata[ERR_EN];
            if (pwdata[ERR_FLAG])
              s_nxt.errFlag = 1'b0;                    // R17
          end
          OFS_INTERRUPT_CONTROL_REG: s_nxt.intMask = pwdata[INT_W-1:0];
          OFS_INT_DIR: s_nxt.route   = pwdata[DIR_ROUTE];
          default: ;
        endcase
      end else if (paddr[7:0] == OFS_INT_STAT) begin
        // clear only what was shown, a newer event survives the read
        s_nxt.intStat = s_r.intStat & ~s_r.prdata[INT_W-1:0];
      end
    end

    // pci attempt decision, first matching cause wins
    if (reqValid) begin
      match = (s_r.dWrite == reqWrite) && (s_r.dAddr == reqAddr);
      if (frozen) begin
        term = T_RETRY;                                // R13
      end else if (reqWrite && otherReadBusy) begin
        // a write never overtakes a read still open on its far bus
        term = T_RETRY;                                // R5
      end else if (s_r.dState == D_DONE && match) begin
        term = s_r.dErr ? T_ABORT : T_DONE;            // R8 R6
        s_nxt.respData = s_r.dRdata;
        s_nxt.dState   = D_IDLE;
        if (s_r.dErr)
          s_nxt.intStat[INT_ABORT] = 1'b1;
      end else if (s_r.dState != D_IDLE) begin
        term = T_RETRY;                                // R3 R4 R7
      end else if (reqWrite && s_r.posted_write_enable) begin
        if ((reqFirst && freeSlots < needSlots) || freeSlots == '0) begin
          term = T_RETRY;                              // R2
        end else begin
          push = 1'b1;
          term = T_DONE;                               // R10
          s_nxt.fifo[s_r.wp] = '{addr: reqAddr, data: reqData,
                                 code: reqCode, size: reqSize};
        end
      end else begin
        // open a delayed read or delayed write and retry meanwhile
        term          = T_RETRY;                       // R7
        s_nxt.dState  = D_RUN;
        s_nxt.dWrite  = reqWrite;
        s_nxt.dAddr   = reqAddr;
        s_nxt.dData   = reqData;
        s_nxt.dCode   = reqCode;
        s_nxt.dSize   = reqSize;
      end
    end
    {s_nxt.stopN, s_nxt.trdyN, s_nxt.devselN} = termPins(term); // R1 R6

    // local bus master; queued posted writes go before delayed ones
    unique case (s_r.lbState)
      L_IDLE: begin
        if (s_r.cnt != '0 && !frozen) begin            // R13
          s_nxt.lbState = L_POST;
          s_nxt.lbReq   = 1'b1;
          s_nxt.lbWrite = 1'b1;
          s_nxt.lbAddr  = s_r.fifo[s_r.rp].addr;
          s_nxt.lbData  = s_r.fifo[s_r.rp].data;
          s_nxt.lbCode  = s_r.fifo[s_r.rp].code;
          s_nxt.lbSize  = s_r.fifo[s_r.rp].size;
        end else if (s_r.dState == D_RUN && s_r.cnt == '0 && !frozen) begin
          s_nxt.lbState = L_DLY;
          s_nxt.lbReq   = 1'b1;
          s_nxt.lbWrite = s_r.dWrite;
          s_nxt.lbAddr  = s_r.dAddr;
          s_nxt.lbData  = s_r.dData;
          s_nxt.lbCode  = s_r.dCode;
          s_nxt.lbSize  = s_r.dSize;
        end
      end
      L_POST: begin
        if (lbAck && lbResp != LB_RETRY) begin
          pop           = 1'b1;
          s_nxt.lbReq   = 1'b0;
          s_nxt.lbState = L_IDLE;
          if (lbResp == LB_ERR && s_r.logEn) begin
            s_nxt.errFlag = 1'b1;                      // R11
            s_nxt.errCode = s_r.lbCode;                // R11
            s_nxt.errSize = s_r.lbSize;
            s_nxt.errAddr = s_r.lbAddr;                // R12
            s_nxt.errData = s_r.lbData;                // R12
            s_nxt.intStat[INT_ERRLOG] = 1'b1;
          end else if (lbResp == LB_ERR) begin
            s_nxt.intStat[INT_DROP] = 1'b1;            // R14
          end
        end
      end
      L_DLY: begin
        // a local retry keeps the request up and is not passed on
        if (lbAck && lbResp != LB_RETRY) begin         // R9
          s_nxt.lbReq   = 1'b0;
          s_nxt.lbState = L_IDLE;
          s_nxt.dState  = D_DONE;
          s_nxt.dErr    = (lbResp == LB_ERR);          // R8
          s_nxt.dRdata  = lbRdata;
        end
      end
      default: s_nxt.lbState = L_IDLE;
    endcase

    // queue pointers
    if (push)
      s_nxt.wp = PTR_W'(s_r.wp + 1'b1);
    if (pop)
      s_nxt.rp = PTR_W'(s_r.rp + 1'b1);
    s_nxt.cnt = CNT_W'(s_r.cnt + {3'h0, push} - {3'h0, pop});
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r         <= '0;
      s_r.stopN   <= 1'b1;
      s_r.trdyN   <= 1'b1;
      s_r.devselN <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; the apb slave never waits
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~regKnown(paddr[7:0]);
  assign prdata   = s_r.prdata;
  assign stopN    = s_r.stopN;
  assign trdyN    = s_r.trdyN;
  assign devselN  = s_r.devselN;
  assign respData = s_r.respData;
  assign lbReq    = s_r.lbReq;
  assign lbWrite  = s_r.lbWrite;
  assign lbAddr   = s_r.lbAddr;
  assign lbData   = s_r.lbData;
  assign lbCode   = s_r.lbCode;
  assign lbSize   = s_r.lbSize;
  // one level, steered to one side only
  assign irqLocal = |(s_r.intStat & s_r.intMask) & ~s_r.route; // R15 R16
  assign irqPci   = |(s_r.intStat & s_r.intMask) & s_r.route;  // R16

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence sRetry;
    !stopN && trdyN && !devselN;
  endsequence
  sequence sDone;
    stopN && !trdyN && !devselN;
  endsequence
  sequence sAbort;
    !stopN && trdyN && devselN;
  endsequence
  sequence sPostErr;
    s_r.lbState == L_POST && lbAck && lbResp == LB_ERR;
  endsequence

  a_retry_shape: assert property (!stopN && !devselN |-> trdyN) // R1
    else $error("retry with trdy asserted");
  a_line_retry: assert property (reqValid && reqWrite && reqFirst &&
      s_r.posted_write_enable && !frozen && s_r.dState == D_IDLE && !otherReadBusy &&
      freeSlots < needSlots |=> sRetry) // R2
    else $error("posted write taken without room");
  a_dly_busy: assert property (reqValid && s_r.dState == D_RUN
      |=> sRetry) // R3
    else $error("access not retried while delayed pending");
  a_write_order: assert property (reqValid && reqWrite && otherReadBusy
      |=> sRetry) // R5
    else $error("write passed an incomplete read");
  a_abort_xlate: assert property (reqValid && !frozen &&
      s_r.dState == D_DONE && s_r.dErr && s_r.dAddr == reqAddr &&
      s_r.dWrite == reqWrite |=> sAbort) // R8
    else $error("local error not turned into abort");
  a_local_hidden: assert property (s_r.lbState == L_DLY && lbAck &&
      lbResp == LB_RETRY |=> lbReq && s_r.dState == D_RUN) // R9
    else $error("local retry ended delayed transaction");
  a_post_done: assert property (reqValid && reqWrite && s_r.posted_write_enable &&
      !frozen && s_r.dState == D_IDLE && !otherReadBusy &&
      freeSlots >= needSlots |=> sDone ##1 s_r.cnt != '0) // R10
    else $error("posted write not completed");
  a_log_capture: assert property (sPostErr and s_r.logEn |=> s_r.errFlag &&
      s_r.errAddr == $past(lbAddr) && s_r.errData == $past(lbData) &&
      s_r.errCode == $past(lbCode)) // R11
    else $error("posted write error not captured");
  a_freeze_hold: assert property (frozen && s_r.lbState == L_IDLE
      |=> !lbReq) // R13
    else $error("queue drained while frozen");
  a_drop_go: assert property (sPostErr and !s_r.logEn |=>
      s_r.errFlag == $past(s_r.errFlag) &&
      s_r.intStat[INT_DROP] && s_r.lbState == L_IDLE) // R14
    else $error("dropped write stalled the queue");
  a_irq_gate: assert property (s_r.intStat[INT_ERRLOG] &&
      !s_r.intMask[INT_ERRLOG] && s_r.intStat[INT_DROP:INT_ABORT] == '0
      |-> !irqLocal && !irqPci) // R15
    else $error("error interrupt without enable");
  a_irq_route: assert property (irqPci |-> s_r.route && !irqLocal) // R16
    else $error("interrupt on wrong side");
  a_err_stable: assert property (s_r.errFlag && !(psel && penable &&
      pwrite && paddr[7:0] == OFS_ERR_CS) |=> s_r.errFlag &&
      $stable(s_r.errAddr) && $stable(s_r.errData)) // R17
    else $error("error log changed before clear");

endmodule

// *** sim/pte_lb_model.sv ***
// local processor bus responder with programmable delay and result
`timescale 1ns/1ps
module pte_lb_model (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst,
  // request from the block
  input  wire logic                    lbReq,
  input  wire logic                    lbWrite,
  input  wire logic [pte_pkg::DW-1:0]  lbAddr,
  // behaviour chosen by the bench
  input  wire pte_pkg::pte_lbresp_t    finalResp,
  input  wire logic [3:0]              waitCyc,
  input  wire logic [1:0]              nRetry,
  // answer and bookkeeping
  output logic                         lbAck,
  output pte_pkg::pte_lbresp_t         lbResp,
  output logic [pte_pkg::DW-1:0]       lbRdata,
  output logic [7:0]                   nWr
);
  import pte_pkg::*;
  logic [3:0] cnt;
  logic [1:0] rtr;
  // retries first, then the final result; read data is junk outside acks
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lbAck <= 1'b0;
      lbResp <= LB_OK;
      lbRdata <= 32'h0;
      nWr <= 8'h0;
      cnt <= 4'h0;
      rtr <= 2'h0;
    end else begin
      lbAck <= 1'b0;
      lbRdata <= ~lbRdata;
      if (lbReq && !lbAck) begin
        cnt <= cnt + 4'h1;
        if (cnt >= waitCyc) begin
          cnt <= 4'h0;
          lbAck <= 1'b1;
          lbRdata <= lbAddr ^ 32'h5a5a0000;
          if (rtr < nRetry) begin
            lbResp <= LB_RETRY;
            rtr <= rtr + 2'h1;
          end else begin
            lbResp <= finalResp;
            rtr <= 2'h0;
            nWr <= nWr + {7'h0, lbWrite};
          end
        end
      end
    end
  end
endmodule

// *** sim/test_pte_target_term.sv ***
// self-checking bench of the pci target termination and error logging
`timescale 1ns/1ps
module test_pte_target_term;
  import pte_pkg::*;
  localparam logic [2:0] CMP = 3'b100;
  localparam logic [2:0] RTY = 3'b010;
  localparam logic [2:0] ABT = 3'b011;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, err;
  logic reqValid = 1'b0, reqWrite = 1'b0, otherReadBusy = 1'b0;
  logic reqFirst = 1'b1;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, s;
  logic [31:0] reqAddr = 32'h0, reqData = 32'h0, respData;
  logic [31:0] lbAddr, lbData, lbRdata, seed = 32'h451fae0b;
  logic [3:0] reqCode = 4'h0, lbCode, waitCyc = 4'h0;
  logic [1:0] reqSize = 2'h0, lbSize, nRetry = 2'h0;
  logic stopN, trdyN, devselN, lbReq, lbWrite, lbAck, irqLocal, irqPci;
  logic [7:0] nWr, t8;
  logic [2:0] p;
  pte_lbresp_t lbResp, finalResp = LB_OK;
  int failures = 0, n_checks = 0, i, k;

  pte_target_term dut_u (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqFirst(reqFirst),
    .reqAddr(reqAddr), .reqData(reqData), .reqCode(reqCode),
    .reqSize(reqSize), .otherReadBusy(otherReadBusy), .stopN(stopN),
    .trdyN(trdyN), .devselN(devselN), .respData(respData), .lbReq(lbReq),
    .lbWrite(lbWrite), .lbAddr(lbAddr), .lbData(lbData),
    .lbCode(lbCode), .lbSize(lbSize), .lbAck(lbAck), .lbResp(lbResp),
    .lbRdata(lbRdata), .irqLocal(irqLocal), .irqPci(irqPci));
  pte_lb_model lb_u (.mclk(mclk), .rst(rst), .lbReq(lbReq),
    .lbWrite(lbWrite), .lbAddr(lbAddr), .finalResp(finalResp),
    .waitCyc(waitCyc), .nRetry(nRetry), .lbAck(lbAck), .lbResp(lbResp),
    .lbRdata(lbRdata), .nWr(nWr));

  // free-running bench clock, 8 ns
  always #4 mclk = ~mclk;

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [2:0] expTerm(input pte_lbresp_t r);
    return (r == LB_OK) ? CMP : ABT;
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // apb master; #1 at the end lets the access edge's updates land
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) failures++;
    if (pready !== 1'b1) give_verdict();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // one pci address phase; the termination shows the cycle after
  task automatic pci(input logic w, input logic [31:0] a, d);
    @(posedge mclk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqAddr <= a;
    reqData <= d;
    @(posedge mclk);
    reqValid <= 1'b0;
    #1 p = {stopN, trdyN, devselN};
  endtask
  task automatic drain(input logic [7:0] t);
    int n;
    n = 0;
    while (nWr !== t && n < 600) begin
      @(posedge mclk);
      #1 n++;
    end
    if (nWr !== t) failures++;
    if (nWr !== t) give_verdict();
  endtask
  // delayed access; others are turned away while it is pending
  task automatic delayed(input logic w, input pte_lbresp_t r);
    int n;
    seed = xs(seed);
    finalResp <= r;
    nRetry <= 2'h2;
    waitCyc <= {1'b0, seed[2:0]};
    pci(w, seed, ~seed);
    chk(p, RTY);
    pci(w, seed ^ 32'h100, ~seed);
    chk(p, RTY);
    pci(1'b1, seed ^ 32'h200, ~seed);
    chk(p, RTY);
    n = 0;
    do begin
      pci(w, seed, ~seed);
      n++;
    end while (p === RTY && n < 60);
    chk(p, expTerm(r));
    if (!w && r == LB_OK) chk(respData, seed ^ 32'h5a5a0000);
  endtask
  // fill the posted queue while the local bus is slow
  task automatic fill(input logic [31:0] misc, input int okN, rtyN);
    int acc;
    apb(1'b1, OFS_MISC, misc);
    finalResp <= LB_OK;
    nRetry <= 2'h0;
    waitCyc <= 4'hf;
    t8 = nWr;
    acc = 0;
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      pci(1'b1, seed, ~seed);
      if (p === CMP) acc++;
      if (i < okN) chk(p, CMP);
      if (i >= rtyN) chk(p, RTY);
    end
    drain(t8 + 8'(acc));
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (k = 0; k < 7; k++) begin
      apb(1'b0, 8'(k * 4), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (k = 0; k < 4; k++) delayed(k[0], k[1] ? LB_ERR : LB_OK);
    fill(32'h1, 5, 5);
    fill(32'h5, 1, 1);
    // a burst continuation needs only one free entry, a first phase a line
    t8 = nWr;
    for (k = 0; k < 3; k++) begin
      seed = xs(seed);
      reqFirst <= (k != 1);
      pci(1'b1, seed, ~seed);
      chk(p, k == 2 ? RTY : CMP);
    end
    drain(t8 + 8'h2);
    otherReadBusy <= 1'b1;
    pci(1'b1, seed, seed);
    chk(p, RTY);
    otherReadBusy <= 1'b0;
    waitCyc <= 4'h2;
    nRetry <= 2'h1;
    // logged error: enabled and routed local, enabled and routed pci, then masked with local route
    for (k = 0; k < 3; k++) begin
      apb(1'b1, OFS_INTERRUPT_CONTROL_REG, {31'h0, k < 2});
      apb(1'b1, OFS_INT_DIR, {31'h0, k[0]});
      apb(1'b1, OFS_ERR_CS, 32'h1);
      apb(1'b0, OFS_INT_STAT, 32'h0);
      finalResp <= LB_ERR;
      s = xs(seed);
      seed = s;
      reqCode <= s[7:4];
      reqSize <= s[9:8];
      t8 = nWr;
      pci(1'b1, s, ~s);
      chk(p, CMP);
      drain(t8 + 8'h1);
      apb(1'b0, OFS_ERR_CS, 32'h0);
      chk({rd[9:4], rd[1:0]}, {s[9:4], 2'b11});
      apb(1'b0, OFS_ERR_ADDR, 32'h0);
      chk(rd, s);
      apb(1'b0, OFS_ERR_DATA, 32'h0);
      chk(rd, ~s);
      chk({irqPci, irqLocal}, k == 2 ? 0 : (k == 1 ? 2 : 1));
      finalResp <= LB_OK;
      pci(1'b1, ~s, s);
      chk(p, RTY);
      apb(1'b0, OFS_INT_STAT, 32'h0);
      chk(rd[0], 1'b1);
      chk({irqPci, irqLocal}, 0);
      apb(1'b1, OFS_ERR_CS, 32'h3);
      pci(1'b1, ~s, s);
      chk(p, CMP);
      drain(t8 + 8'h2);
    end
    // logging off: failed posted writes are dropped; short line so both fit
    apb(1'b1, OFS_MISC, 32'h1);
    apb(1'b1, OFS_ERR_CS, 32'h0);
    finalResp <= LB_ERR;
    t8 = nWr;
    pci(1'b1, s, s);
    chk(p, CMP);
    pci(1'b1, ~s, s);
    chk(p, CMP);
    drain(t8 + 8'h2);
    apb(1'b0, OFS_ERR_CS, 32'h0);
    chk(rd[1], 1'b0);
    apb(1'b0, OFS_INT_STAT, 32'h0);
    chk(rd[2], 1'b1);
    give_verdict();
  end
endmodule
